//--- cap_cmp_defines.svh
/*
 * Register offsets, field positions, reset values and timebase divisors for the
 * counter array. Assumes a 32-bit AXI4-Lite slave with one register per word.
 */
`ifndef CAP_CMP_DEFINES_SVH
`define CAP_CMP_DEFINES_SVH
`define OFS_COUNT_LOW      8'h00
`define OFS_COUNT_HIGH     8'h04
`define OFS_ARRAY_MODE     8'h08
`define OFS_ARRAY_CTRL     8'h0c
`define OFS_MOD_CONFIG     8'h10
`define OFS_MODE0          8'h20
`define OFS_CMP_LOW0       8'h24
`define OFS_CMP_HIGH0      8'h28
`define MODULE_STRIDE      8'h10
`define MODE_WD_RESET      8'h40
`define ARRAY_MODE_RESET   8'h40
`define WD_ENABLE_BIT      6
`define DIV12              4'd11
`define DIV4               4'd3
`define EXT_DIV8           3'd7
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10
`endif

//--- cap_cmp_pkg.sv
/*
 * Types shared by the counter array: the timebase codes.
 * Assumes nothing of its surroundings.
 */
package cap_cmp_pkg;
    typedef enum logic [2:0] {
        TB_DIV12 = 3'h0,
        TB_DIV4  = 3'h1,
        TB_TMR0  = 3'h2,
        TB_ECI   = 3'h3,
        TB_SYS   = 3'h4,
        TB_EXT8  = 3'h5
    } timebase_t;
endpackage

//--- counter_array.sv
/*
 * Counter array with a 16-bit shared counter and three capture/compare modules,
 * reached over AXI4-Lite. Assumes pins and the external oscillator are asynchronous
 * to mclk; timer0 overflow is a one-cycle pulse on mclk.
 */
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "cap_cmp_defines.svh"
module counter_array
    import cap_cmp_pkg::*;
#(
    parameter int NMOD = 3
) (
    input  wire logic             mclk,
    input  wire logic             reset_n,
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic             count_input_pin,
    input  wire logic             ext_osc_div8,
    input  wire logic             timer0_overflow,
    input  wire logic             cpu_idle,
    input  wire logic             global_irq_enable,
    input  wire logic [NMOD-1:0]  module_pin_in,
    output logic [NMOD-1:0]       module_pin_out,
    output logic [NMOD-1:0]       module_pin_oe,
    output logic                  watchdog_reset,
    output logic                  array_irq
);
    typedef struct packed {
        logic [15:0]            count;
        logic [7:0]             snap;
        logic [3:0]             presc;
        logic [1:0]             eci_s;
        logic                   eci_d;
        logic [1:0]             ext_s;
        logic                   ext_d;
        logic                   idle_suspend;
        logic                   wrap_irq_enable;
        logic [2:0]             timebase_select;
        logic                   counter_wrap_flag;
        logic                   array_irq_enable;
        logic                   partial_overflow_flag;
        logic                   partial_overflow_irq_enable;
        logic                   reload_reg_select;
        logic [1:0]             cycle_length_select;
        logic [NMOD-1:0][7:0]   mode;
        logic [NMOD-1:0][15:0]  cc;
        logic [NMOD-1:0][15:0]  reload;
        logic [NMOD-1:0]        module_event_flag;
        logic [NMOD-1:0][1:0]   pin_s;
        logic [NMOD-1:0]        pin_d;
        logic [NMOD-1:0]        pin_q;
        logic                   wd_hit;
        logic                   aw_got;
        logic                   w_got;
        logic [7:0]             awaddr;
        logic [31:0]            wdata;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    logic tick;
    logic [15:0] cnt_inc;
    logic [11:0] mask_n;
    logic ovf_n;
    logic wr_go;
    logic rd_go;
    logic wd_on;
    logic [7:0] wa;
    logic [7:0] ra;
    logic [7:0] wb;
    logic [1:0] widx;
    logic [1:0] ridx;
    logic [7:0] wofs;
    logic [7:0] rofs;
    logic [3:0] nbits;
    logic [NMOD-1:0] rise;
    logic [NMOD-1:0] fall;
    logic [NMOD-1:0] ev_set;

    assign wd_on = st_ff.mode[2][`WD_ENABLE_BIT] && (NMOD > 2);
    assign nbits = 4'(8 + st_ff.cycle_length_select);
    assign mask_n = 12'((13'h1 << nbits) - 13'h1);
    assign wr_go = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
    assign rd_go = s_axi_arvalid && !st_ff.rvalid;
    assign wa = st_ff.awaddr;
    assign ra = s_axi_araddr;
    assign wb = st_ff.wdata[7:0];
    assign widx = 2'((wa - `OFS_MODE0) >> 4);
    assign ridx = 2'((ra - `OFS_MODE0) >> 4);
    assign wofs = 8'(wa - `OFS_MODE0 - 8'(widx * `MODULE_STRIDE));
    assign rofs = 8'(ra - `OFS_MODE0 - 8'(ridx * `MODULE_STRIDE));

    assign s_axi_awready = !st_ff.aw_got;
    assign s_axi_wready  = !st_ff.w_got;
    assign s_axi_bvalid  = st_ff.bvalid;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_arready = !st_ff.rvalid;
    assign s_axi_rvalid  = st_ff.rvalid;
    assign s_axi_rdata   = st_ff.rdata;
    assign s_axi_rresp   = st_ff.rresp;
    assign module_pin_out = st_ff.pin_q;
    assign watchdog_reset = st_ff.wd_hit;

    always_comb begin
        nxt_st = st_ff;
        tick = 1'b0;
        ovf_n = 1'b0;
        rise = '0;
        fall = '0;
        cnt_inc = 16'h0000;
        // Pins pass two flops; edge detection reads only the second stage.
        nxt_st.eci_s = {st_ff.eci_s[0], count_input_pin};
        nxt_st.eci_d = st_ff.eci_s[1];
        nxt_st.ext_s = {st_ff.ext_s[0], ext_osc_div8};
        nxt_st.ext_d = st_ff.ext_s[1];
        for (int m = 0; m < NMOD; m++) begin
            nxt_st.pin_s[m] = {st_ff.pin_s[m][0], module_pin_in[m]};
            nxt_st.pin_d[m] = st_ff.pin_s[m][1];
            rise[m] = st_ff.pin_s[m][1] && !st_ff.pin_d[m];
            fall[m] = !st_ff.pin_s[m][1] && st_ff.pin_d[m];
        end
        nxt_st.presc = st_ff.presc + 4'd1;
        case (timebase_t'(st_ff.timebase_select))
            TB_DIV12: begin
                tick = (st_ff.presc >= `DIV12);
                if (tick) nxt_st.presc = 4'd0;
            end
            TB_DIV4: begin
                tick = (st_ff.presc >= `DIV4);
                if (tick) nxt_st.presc = 4'd0;
            end
            TB_TMR0: tick = timer0_overflow;
            TB_ECI:  tick = !st_ff.eci_s[1] && st_ff.eci_d;
            TB_SYS:  tick = 1'b1;
            TB_EXT8: tick = st_ff.ext_s[1] && !st_ff.ext_d;
            default: tick = 1'b0;
        endcase
        // Idle only stalls the array when software asked for it.
        if (cpu_idle && st_ff.idle_suspend) tick = 1'b0;
        if (tick) begin
            cnt_inc = st_ff.count + 16'h0001;
            nxt_st.count = cnt_inc;
            ovf_n = ((st_ff.count[11:0] & mask_n) == mask_n);
            if (st_ff.count == 16'hffff) nxt_st.counter_wrap_flag = 1'b1;
            if (ovf_n) nxt_st.partial_overflow_flag = 1'b1;
        end
        nxt_st.wd_hit = 1'b0;
        // Module sets are gathered alone first, so a clear can spare a flag set again.
        nxt_st.module_event_flag = '0;
        for (int m = 0; m < NMOD; m++) begin : per_mod
            logic [7:0] md;
            logic cmp_on;
            logic pwm16;
            logic match16;
            md = st_ff.mode[m];
            cmp_on = md[6];
            pwm16 = md[7];
            match16 = tick && (st_ff.count == st_ff.cc[m]);
            module_pin_oe[m] = (md[3:1] != 3'b000);
            if (md[3:1] == 3'b000) begin
                if ((md[5] && rise[m]) || (md[4] && fall[m])) begin
                    nxt_st.cc[m] = st_ff.count;
                    nxt_st.module_event_flag[m] = 1'b1;
                end
            end else if (md[5:4] == 2'b00 && md[3:1] == 3'b100) begin
                if (cmp_on && match16) nxt_st.module_event_flag[m] = 1'b1;
                if (m == 2 && wd_on && match16) nxt_st.wd_hit = 1'b1;
            end else if (md[5:4] == 2'b00 && md[3:1] == 3'b110) begin
                if (cmp_on && match16) begin
                    nxt_st.pin_q[m] = !st_ff.pin_q[m];
                    nxt_st.module_event_flag[m] = 1'b1;
                end
            end else if (md[5:4] == 2'b00 && md[3:1] == 3'b011) begin
                if (cmp_on && tick && st_ff.count[7:0] == st_ff.cc[m][7:0]) begin
                    nxt_st.pin_q[m] = !st_ff.pin_q[m];
                    nxt_st.cc[m][7:0] = st_ff.cc[m][7:0] + st_ff.cc[m][15:8];
                end
                if (md[3] && match16) nxt_st.module_event_flag[m] = 1'b1;
            end else if (md[5:4] == 2'b00 && md[2:1] == 2'b01) begin
                if (!cmp_on) begin
                    nxt_st.pin_q[m] = 1'b0;
                end else if (pwm16) begin
                    if (match16) nxt_st.pin_q[m] = 1'b1;
                    else if (tick && st_ff.count == 16'hffff) nxt_st.pin_q[m] = 1'b0;
                    if (md[3] && match16) nxt_st.module_event_flag[m] = 1'b1;
                end else begin
                    // One shared cycle length for every narrow modulator.
                    if (tick && (st_ff.count[11:0] & mask_n) == (st_ff.cc[m][11:0] & mask_n)) begin
                        nxt_st.pin_q[m] = 1'b1;
                        if (md[3]) nxt_st.module_event_flag[m] = 1'b1;
                    end else if (ovf_n) begin
                        nxt_st.pin_q[m] = 1'b0;
                    end
                    if (ovf_n) begin
                        if (st_ff.cycle_length_select == 2'b00)
                            nxt_st.cc[m][7:0] = st_ff.cc[m][15:8];
                        else
                            nxt_st.cc[m] = st_ff.reload[m];
                    end
                end
            end
        end
        ev_set = nxt_st.module_event_flag;
        nxt_st.module_event_flag = st_ff.module_event_flag | ev_set;
        // Bus write: flags clear on zero, but a same-cycle hardware set wins.
        if (s_axi_awvalid && !st_ff.aw_got) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_ff.w_got) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = s_axi_wdata;
        end
        if (st_ff.bvalid && s_axi_bready) nxt_st.bvalid = 1'b0;
        if (wr_go) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = `RESP_OKAY;
            if (!st_ff.wdata[0] && st_ff.wdata[3:0] != 4'h0) nxt_st.bresp = `RESP_OKAY;
            if (!s_axi_wstrb[0] && st_ff.w_got) nxt_st.bresp = `RESP_OKAY;
            case (wa)
                `OFS_COUNT_LOW: if (!wd_on) nxt_st.count[7:0] = wb;
                `OFS_COUNT_HIGH: if (!wd_on) nxt_st.count[15:8] = wb;
                `OFS_ARRAY_MODE: begin
                    if (!wd_on || !wb[`WD_ENABLE_BIT]) begin
                        nxt_st.idle_suspend = wb[7];
                        nxt_st.timebase_select = wb[3:1];
                        nxt_st.wrap_irq_enable = wb[0];
                        if (NMOD > 2) nxt_st.mode[2][`WD_ENABLE_BIT] = wb[`WD_ENABLE_BIT];
                    end
                end
                `OFS_ARRAY_CTRL: begin
                    if (!wb[7] && !nxt_st.counter_wrap_flag) nxt_st.counter_wrap_flag = 1'b0;
                    if (!wb[7] && !(tick && st_ff.count == 16'hffff))
                        nxt_st.counter_wrap_flag = 1'b0;
                    nxt_st.array_irq_enable = wb[6];
                    for (int m = 0; m < NMOD; m++)
                        if (!wb[m] && !ev_set[m])
                            nxt_st.module_event_flag[m] = 1'b0;
                end
                `OFS_MOD_CONFIG: begin
                    nxt_st.reload_reg_select = wb[7];
                    if (!wb[6] && !(tick && ovf_n)) nxt_st.partial_overflow_flag = 1'b0;
                    nxt_st.partial_overflow_irq_enable = wb[5];
                    nxt_st.cycle_length_select = wb[1:0];
                end
                default: begin
                    if (wa >= `OFS_MODE0 && widx < 2'(NMOD)) begin
                        if (wofs == 8'h00 && !(widx == 2'd2 && wd_on)) nxt_st.mode[widx] = wb;
                        if (wofs == 8'h04 || wofs == 8'h08) begin
                            if (st_ff.reload_reg_select && st_ff.cycle_length_select != 2'b00) begin
                                if (wofs == 8'h04) nxt_st.reload[widx][7:0] = wb;
                                else nxt_st.reload[widx][15:8] = wb;
                            end else if (wofs == 8'h04) begin
                                nxt_st.cc[widx][7:0] = wb;
                                nxt_st.mode[widx][6] = 1'b0;
                            end else begin
                                nxt_st.cc[widx][15:8] = wb;
                                nxt_st.mode[widx][6] = 1'b1;
                            end
                        end
                    end else begin
                        nxt_st.bresp = `RESP_SLVERR;
                    end
                end
            endcase
        end
        // Bus read.
        if (st_ff.rvalid && s_axi_rready) nxt_st.rvalid = 1'b0;
        if (rd_go) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = `RESP_OKAY;
            nxt_st.rdata = 32'h0000_0000;
            case (ra)
                `OFS_COUNT_LOW: begin
                    nxt_st.rdata[7:0] = st_ff.count[7:0];
                    nxt_st.snap = st_ff.count[15:8];
                end
                `OFS_COUNT_HIGH: nxt_st.rdata[7:0] = st_ff.snap;
                `OFS_ARRAY_MODE: nxt_st.rdata[7:0] = {st_ff.idle_suspend, wd_on,
                    2'b00, st_ff.timebase_select, st_ff.wrap_irq_enable};
                `OFS_ARRAY_CTRL: nxt_st.rdata[7:0] = {st_ff.counter_wrap_flag,
                    st_ff.array_irq_enable, 3'b000, 3'(st_ff.module_event_flag)};
                `OFS_MOD_CONFIG: nxt_st.rdata[7:0] = {st_ff.reload_reg_select,
                    st_ff.partial_overflow_flag, st_ff.partial_overflow_irq_enable,
                    3'b000, st_ff.cycle_length_select};
                default: begin
                    if (ra >= `OFS_MODE0 && ridx < 2'(NMOD)) begin
                        if (rofs == 8'h00) nxt_st.rdata[7:0] = st_ff.mode[ridx];
                        else if (rofs == 8'h04)
                            nxt_st.rdata[7:0] = (st_ff.reload_reg_select &&
                                st_ff.cycle_length_select != 2'b00) ?
                                st_ff.reload[ridx][7:0] : st_ff.cc[ridx][7:0];
                        else if (rofs == 8'h08)
                            nxt_st.rdata[7:0] = (st_ff.reload_reg_select &&
                                st_ff.cycle_length_select != 2'b00) ?
                                st_ff.reload[ridx][15:8] : st_ff.cc[ridx][15:8];
                        else nxt_st.rresp = `RESP_SLVERR;
                    end else begin
                        nxt_st.rresp = `RESP_SLVERR;
                    end
                end
            endcase
        end
    end

    // Interrupt request: enabled flags ORed, then gated by both enables.
    assign array_irq = global_irq_enable && st_ff.array_irq_enable && (
        (st_ff.counter_wrap_flag && st_ff.wrap_irq_enable) ||
        (st_ff.partial_overflow_flag && st_ff.partial_overflow_irq_enable) ||
        |(st_ff.module_event_flag & {st_ff.mode[2][0], st_ff.mode[1][0], st_ff.mode[0][0]}));

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
            st_ff.mode[2] <= `MODE_WD_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    property p_wrap;
        @(posedge mclk) disable iff (!reset_n)
        (tick && st_ff.count == 16'hffff) |=> (st_ff.counter_wrap_flag && st_ff.count == 16'h0000);
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap flag not set on wrap");

    property p_irq;
        @(posedge mclk) disable iff (!reset_n)
        (!st_ff.array_irq_enable || !global_irq_enable) |-> !array_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt without enables");

    property p_sys;
        @(posedge mclk) disable iff (!reset_n)
        (st_ff.timebase_select == 3'h4 && !(cpu_idle && st_ff.idle_suspend) && !wr_go)
        |=> st_ff.count == $past(st_ff.count) + 16'h0001;
    endproperty
    a_sys: assert property (p_sys) else $error("counter missed system clock tick");

    property p_stay;
        @(posedge mclk) disable iff (!reset_n)
        (st_ff.counter_wrap_flag && !wr_go) |=> st_ff.counter_wrap_flag;
    endproperty
    a_stay: assert property (p_stay) else $error("wrap flag cleared by itself");

    property p_off;
        @(posedge mclk) disable iff (!reset_n)
        (st_ff.mode[0][5:4] == 2'b00 && st_ff.mode[0][2:1] == 2'b01 && !st_ff.mode[0][6])
        |=> !st_ff.pin_q[0];
    endproperty
    a_off: assert property (p_off) else $error("modulated output not held low");

    sequence s_rise0;
        st_ff.mode[0][5:1] == 5'b10000 ##0 rise[0];
    endsequence
    property p_cap;
        @(posedge mclk) disable iff (!reset_n)
        s_rise0 |=> (st_ff.module_event_flag[0] && st_ff.cc[0] == $past(st_ff.count));
    endproperty
    a_cap: assert property (p_cap) else $error("capture missed");

    property p_snap;
        @(posedge mclk) disable iff (!reset_n)
        (rd_go && ra == `OFS_COUNT_LOW) |=> st_ff.snap == $past(st_ff.count[15:8]);
    endproperty
    a_snap: assert property (p_snap) else $error("snapshot not taken");

    property p_pov;
        @(posedge mclk) disable iff (!reset_n)
        (tick && st_ff.count[7:0] == 8'hff && st_ff.cycle_length_select == 2'b00)
        |=> st_ff.partial_overflow_flag;
    endproperty
    a_pov: assert property (p_pov) else $error("partial overflow missed");
endmodule

//--- pin_model.sv
/*
 * Model of the pins outside the counter array: the count input and the module pins.
 * Assumes its tasks are entered just after a rising mclk edge.
 */
`timescale 1ns/1ps
module pin_model (
    input  wire logic  mclk,
    output logic       count_input_pin,
    output logic [2:0] module_pin_in
);
    initial count_input_pin = 1'b1;
    initial module_pin_in = 3'h0;
    // Each level lasts four cycles, slower than the fastest count rate allowed.
    task automatic fall_count(input int n);
        repeat (2 * n) begin
            count_input_pin <= ~count_input_pin;
            repeat (4) @(posedge mclk);
        end
    endtask
    task automatic set_pin(input int k, input logic v);
        module_pin_in[k] <= v;
        repeat (6) @(posedge mclk);
    endtask
endmodule

//--- tb_counter_array.sv
/*
 * Self-checking bench for counter_array over AXI4-Lite, with pin_model on the pins.
 * Assumes timer0 is the timebase between scenarios, so the count moves only on pulses.
 */
`timescale 1ns/1ps
module tb_counter_array;
    logic        mclk = 1'b0, reset_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        ext_osc_div8 = 1'b0, timer0_overflow = 1'b0, cpu_idle = 1'b0;
    logic        global_irq_enable = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, count_input_pin, watchdog_reset, array_irq;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [2:0]  module_pin_in, module_pin_out, module_pin_oe;
    logic [15:0] cnt;
    int          num_errors = 0, n_compared = 0;
    always #12.5 mclk = ~mclk;
    counter_array u_dut (.mclk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .count_input_pin, .ext_osc_div8,
        .timer0_overflow, .cpu_idle, .global_irq_enable, .module_pin_in, .module_pin_out,
        .module_pin_oe, .watchdog_reset, .array_irq);
    pin_model u_pins (.mclk, .count_input_pin, .module_pin_in);
    task automatic close_out;
        if (num_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        repeat (64) begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                @(posedge mclk);
                return;
            end
        end
        num_errors++;
        close_out;
    endtask
    // Data is judged only on an OKAY answer; error answers carry no defined data.
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        repeat (64) begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                rsp = s_axi_rresp;
                if (s_axi_rresp == 2'b00) chk(s_axi_rdata[7:0], exp);
                @(posedge mclk);
                return;
            end
        end
        num_errors++;
        close_out;
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            timer0_overflow <= 1'b1;
            @(posedge mclk);
            timer0_overflow <= 1'b0;
            @(posedge mclk);
        end
        cnt = cnt + 16'(n);
    endtask
    task automatic t_reset;
        rc(8'h08, 8'h40);
        rc(8'h40, 8'h40);
        rc(8'hfc, 8'h00);
        chk({6'h0, rsp}, 8'h02);
        wr(8'h08, 8'h04);
        rc(8'h08, 8'h04);
    endtask
    task automatic t_count;
        wr(8'h04, 8'h12);
        wr(8'h00, 8'hfe);
        cnt = 16'h12fe;
        tick(1);
        rc(8'h00, 8'hff);
        tick(1);
        rc(8'h04, 8'h12);
        rc(8'h00, 8'h00);
        rc(8'h04, 8'h13);
    endtask
    task automatic t_wrap;
        wr(8'h10, 8'h00);
        wr(8'h04, 8'hff);
        wr(8'h00, 8'hff);
        cnt = 16'hffff;
        tick(1);
        rc(8'h0c, 8'h80);
        rc(8'h10, 8'h40);
        wr(8'h08, 8'h05);
        wr(8'h0c, 8'hc0);
        chk({7'h0, array_irq}, 8'h00);
        global_irq_enable <= 1'b1;
        repeat (2) @(posedge mclk);
        chk({7'h0, array_irq}, 8'h01);
        wr(8'h08, 8'h04);
        chk({7'h0, array_irq}, 8'h00);
        wr(8'h0c, 8'h40);
        rc(8'h0c, 8'h40);
    endtask
    task automatic t_capture;
        logic [7:0] modes [3];
        modes = '{8'h20, 8'h10, 8'h30};
        for (int i = 0; i < 3; i++) begin
            wr(8'h20, modes[i]);
            wr(8'h0c, 8'h40);
            tick(3);
            u_pins.set_pin(0, i != 1);
            rc(8'h24, cnt[7:0]);
            rc(8'h28, cnt[15:8]);
            rc(8'h0c, 8'h41);
        end
    endtask
    task automatic t_pin;
        wr(8'h08, 8'h06);
        u_pins.fall_count(3);
        wr(8'h08, 8'h04);
        cnt = cnt + 16'd3;
        rc(8'h00, cnt[7:0]);
        wr(8'h08, 8'h08);
        wr(8'h08, 8'h04);
        cnt = cnt + 16'd4;
        rc(8'h00, cnt[7:0]);
        cpu_idle <= 1'b1;
        tick(1);
        cpu_idle <= 1'b0;
        rc(8'h00, cnt[7:0]);
    endtask
    task automatic t_hso;
        logic p;
        wr(8'h0c, 8'h40);
        wr(8'h30, 8'h0c);
        wr(8'h34, cnt[7:0] + 8'd1);
        wr(8'h38, cnt[15:8]);
        rc(8'h30, 8'h4c);
        chk({7'h0, module_pin_oe[1]}, 8'h01);
        p = module_pin_out[1];
        tick(2);
        repeat (2) @(posedge mclk);
        chk({7'h0, module_pin_out[1]}, {7'h0, ~p});
        rc(8'h0c, 8'h42);
        wr(8'h34, cnt[7:0] + 8'd1);
        rc(8'h30, 8'h0c);
        tick(2);
        repeat (2) @(posedge mclk);
        chk({7'h0, module_pin_out[1]}, {7'h0, ~p});
    endtask
    task automatic t_pwm;
        wr(8'h0c, 8'h40);
        wr(8'h20, 8'h0a);
        wr(8'h24, cnt[7:0] + 8'd1);
        wr(8'h28, cnt[7:0] + 8'd1);
        tick(2);
        chk({7'h0, module_pin_out[0]}, 8'h01);
        rc(8'h0c, 8'h41);
        wr(8'h20, 8'h0a);
        chk({7'h0, module_pin_out[0]}, 8'h00);
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        t_reset;
        t_count;
        t_wrap;
        t_capture;
        t_pin;
        t_hso;
        t_pwm;
        close_out;
    end
endmodule
